//--- core/spc_pkg.sv
// Shared constants, modes and the captured symbol type for the parallel input control block.
package spc_pkg;

  localparam int unsigned PIXEL_W = 24;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FILTER_HOLD_CLOCKS = 3;

  localparam int unsigned MCLK_FREQ_MHZ = 125;
  localparam int unsigned LOCK_WAIT_NS = 1000;
  localparam int unsigned LOCK_WAIT_CYCLES = (LOCK_WAIT_NS * MCLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned LOCK_CNT_W = $clog2(LOCK_WAIT_CYCLES + 1);

  localparam logic RST_OVR_EN = 1'b0;
  localparam logic RST_OVR_VALUE = 1'b0;
  localparam logic [PIXEL_W-1:0] BIST_SEED = 24'h000001;

  typedef enum logic [1:0] {
    SPC_MODE_NATIVE_UNFILT = 2'b00,
    SPC_MODE_NATIVE_FILT = 2'b01,
    SPC_MODE_COMPAT_A = 2'b10,
    SPC_MODE_COMPAT_B = 2'b11
  } spc_mode_t;

  typedef enum logic [1:0] {
    SPC_PS_DOWN = 2'b00,
    SPC_PS_LOCKING = 2'b01,
    SPC_PS_ACTIVE = 2'b10
  } spc_pwr_t;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic data_enable;
    logic [PIXEL_W-1:0] pixel;
  } spc_symbol_t;

  localparam int unsigned SYMBOL_W = $bits(spc_symbol_t);

endpackage : spc_pkg

//--- core/spc_input_ctrl.sv
// Parallel pixel capture, control filter, power-down and mode control, with the symbol FIFO.
// Operation
// R1: Filtered sync pulses need three clocks minimum.
// R2: Filter off forwards control changes without minimum.
// R3: Source toggles hsync at most twice per 130.
// R4: Source toggles vsync at most once per 130.
// R5: Edge select high captures on rising edge.
// R6: Edge select low captures on falling edge.
// R7: Power-down high means normal serializing operation.
// R8: Power-down low stops, serial legs both high.
// R9: Control registers reset while powered down.
// R10: Config 00 selects native mode, filter off.
// R11: Config 01 selects native mode, filter on.
// R12: Config 10 selects first backward-compatible mode.
// R13: Config 11 selects second backward-compatible mode.
// R14: Self-test enable high enters link self-test.
// R15: Swing select picks high or low drive.
// R16: Pixel word is red, green, blue lanes.
// R17: Data enable filtered exactly like horizontal sync.
// R18: Word and controls captured on one edge.
// R19: Serial output idles until PLL relocks.
`timescale 1ns/100ps
`default_nettype none

module spc_fifo #(
  parameter int unsigned WIDTH = 27,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic [WIDTH-1:0] out_data_r;
  logic out_valid_r;
  logic push;
  logic load;
  logic from_mem;
  logic bypass;
  logic store;

  // The output stage is a register so the consumer never sees a memory read path.
  always_comb
  begin
    push = in_valid & in_ready;
    load = ~out_valid_r | out_ready;
    from_mem = load & (cnt_r != '0);
    bypass = load & (cnt_r == '0) & push;
    store = push & ~bypass;
  end

  assign in_ready = (cnt_r < DEPTH_CNT);
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  always_ff @(posedge clk)
  begin
    if (store)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst | flush)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (store)
      begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (from_mem)
      begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      if (store & ~from_mem)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (from_mem & ~store)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst | flush)
    begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end
    else if (load)
    begin
      if (from_mem)
      begin
        out_data_r <= mem_r[rd_ptr_r];
        out_valid_r <= 1'b1;
      end
      else if (bypass)
      begin
        out_data_r <= in_data;
        out_valid_r <= 1'b1;
      end
      else
      begin
        out_valid_r <= 1'b0;
      end
    end
  end

  a_fifo_count_bound: assert property (@(posedge clk) disable iff (rst) cnt_r <= DEPTH_CNT) // R18
    else $error("FIFO count exceeds its depth.");
  a_fifo_hold_stalled: assert property (@(posedge clk) disable iff (rst | flush) // R18
    out_valid_r && !out_ready |=> out_valid_r && $stable(out_data_r))
    else $error("FIFO output changed while stalled.");

endmodule : spc_fifo

module spc_ctl_filter #(
  parameter int unsigned HOLD = 3
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic strobe,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  localparam int unsigned CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] LAST_CNT = CW'(HOLD - 1);

  logic [CW-1:0] cnt_r;
  logic dout_r;

  assign dout = dout_r;

  // R1: minimum pulse width
  // A change is forwarded only after it has been seen on HOLD captures in a row; a shorter pulse is dropped.
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      cnt_r <= '0;
      dout_r <= 1'b0;
    end
    else if (strobe)
    begin
      if (din == dout_r)
      begin
        cnt_r <= '0;
      end
      // R2: unfiltered pass-through
      else if (!enable || cnt_r == LAST_CNT)
      begin
        dout_r <= din;
        cnt_r <= '0;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  a_filter_pass_through: assert property (@(posedge clk) disable iff (clr) // R2
    strobe && !enable |=> dout_r == $past(din))
    else $error("Unfiltered control change was not forwarded.");
  a_filter_short_pulse: assert property (@(posedge clk) disable iff (clr) // R1
    strobe && enable && din != dout_r && cnt_r == '0 |=> dout_r == $past(dout_r))
    else $error("Filtered control changed on its first capture.");

endmodule : spc_ctl_filter

module spc_input_ctrl
  import spc_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic PIXEL_CLOCK_IN,
  input wire logic [PIXEL_W-1:0] PIXEL_WORD_IN,
  input wire logic DATA_ENABLE_IN,
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  input wire logic POWER_DOWN_N,
  input wire logic CAPTURE_EDGE_SELECT,
  input wire logic [1:0] CONFIG_SELECT,
  input wire logic SELF_TEST_ENABLE,
  input wire logic SWING_LEVEL_SELECT,
  input wire logic REG_WRITE,
  input wire logic REG_EDGE_OVR_EN,
  input wire logic REG_EDGE_VALUE,
  input wire logic REG_SWING_OVR_EN,
  input wire logic REG_SWING_VALUE,
  input wire logic SYMBOL_READY,
  output logic SYMBOL_VALID,
  output spc_symbol_t SYMBOL_OUT,
  output logic PLL_LOCKED,
  output logic SER_LEGS_HIGH,
  output spc_mode_t LINK_MODE,
  output logic FILTER_ENABLE,
  output logic SELF_TEST_ACTIVE,
  output logic SWING_HIGH,
  output logic CAPTURE_OVERRUN
);
  localparam int LOCK_DLY = int'(LOCK_WAIT_CYCLES);
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_WAIT_CYCLES - 1);

  spc_pwr_t state_r;
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  logic down;
  logic active;
  logic edge_ovr_en_r;
  logic edge_ovr_val_r;
  logic swing_ovr_en_r;
  logic swing_ovr_val_r;
  logic edge_sel_r;
  logic swing_r;
  spc_mode_t mode_r;
  logic filter_en_r;
  logic bist_r;
  logic pclk_prev_r;
  logic rise;
  logic fall;
  logic cap;
  logic [PIXEL_W-1:0] pixel_r;
  logic [PIXEL_W-1:0] bist_pat_r;
  logic vs_r;
  logic de_f;
  logic hs_f;
  logic push_r;
  logic fifo_ready;
  logic pll_locked_r;
  logic legs_high_r;
  logic overrun_r;
  spc_symbol_t fifo_in;
  logic [SYMBOL_W-1:0] fifo_out;

  assign down = SYS_RST | ~POWER_DOWN_N;
  assign active = ~down & (state_r == SPC_PS_ACTIVE);

  // R7: normal operation
  // R19: relock wait
  // The lock wait restarts on every power-up, so a short glitch on power-down costs a full relock.
  always_ff @(posedge MCLK)
  begin
    if (down)
    begin
      state_r <= SPC_PS_DOWN;
      lock_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        SPC_PS_DOWN:
        begin
          state_r <= SPC_PS_LOCKING;
          lock_cnt_r <= '0;
        end
        SPC_PS_LOCKING:
        begin
          if (lock_cnt_r == LOCK_LAST)
          begin
            state_r <= SPC_PS_ACTIVE;
          end
          else
          begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
          end
        end
        SPC_PS_ACTIVE:
        begin
          state_r <= SPC_PS_ACTIVE;
        end
        default:
        begin
          state_r <= SPC_PS_DOWN;
        end
      endcase
    end
  end

  // R8: idle legs high
  always_ff @(posedge MCLK)
  begin
    pll_locked_r <= active;
    legs_high_r <= ~active;
  end

  // R9: reset in power-down
  always_ff @(posedge MCLK)
  begin
    if (down)
    begin
      edge_ovr_en_r <= RST_OVR_EN;
      edge_ovr_val_r <= RST_OVR_VALUE;
      swing_ovr_en_r <= RST_OVR_EN;
      swing_ovr_val_r <= RST_OVR_VALUE;
    end
    else if (REG_WRITE)
    begin
      edge_ovr_en_r <= REG_EDGE_OVR_EN;
      edge_ovr_val_r <= REG_EDGE_VALUE;
      swing_ovr_en_r <= REG_SWING_OVR_EN;
      swing_ovr_val_r <= REG_SWING_VALUE;
    end
  end

  // R10: mode decode
  // R11: filter enable
  // R12: compatibility modes
  // R13: compatibility modes
  // R15: swing selection
  always_ff @(posedge MCLK)
  begin
    if (down)
    begin
      edge_sel_r <= RST_OVR_VALUE;
      swing_r <= RST_OVR_VALUE;
      mode_r <= SPC_MODE_NATIVE_UNFILT;
      filter_en_r <= 1'b0;
      bist_r <= 1'b0;
    end
    else
    begin
      edge_sel_r <= edge_ovr_en_r ? edge_ovr_val_r : CAPTURE_EDGE_SELECT;
      swing_r <= swing_ovr_en_r ? swing_ovr_val_r : SWING_LEVEL_SELECT;
      mode_r <= spc_mode_t'(CONFIG_SELECT);
      filter_en_r <= (spc_mode_t'(CONFIG_SELECT) == SPC_MODE_NATIVE_FILT);
      bist_r <= SELF_TEST_ENABLE;
    end
  end

  // The pixel clock is oversampled, so it must stay well below half the system clock.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pclk_prev_r <= 1'b0;
    end
    else
    begin
      pclk_prev_r <= PIXEL_CLOCK_IN;
    end
  end

  assign rise = PIXEL_CLOCK_IN & ~pclk_prev_r;
  assign fall = ~PIXEL_CLOCK_IN & pclk_prev_r;
  // R5: rising edge capture
  // R6: falling edge capture
  assign cap = active & (edge_sel_r ? rise : fall);

  // R14: self-test pattern
  // R16: lane order
  // R18: one symbol per edge
  // R4: vsync is not filtered
  always_ff @(posedge MCLK)
  begin
    if (down)
    begin
      pixel_r <= '0;
      vs_r <= 1'b0;
      bist_pat_r <= BIST_SEED;
      push_r <= 1'b0;
    end
    else
    begin
      push_r <= cap;
      if (cap)
      begin
        vs_r <= VSYNC_IN;
        if (bist_r)
        begin
          pixel_r <= bist_pat_r;
          bist_pat_r <= bist_pat_r + 1'b1;
        end
        else
        begin
          pixel_r <= PIXEL_WORD_IN;
        end
      end
    end
  end

  // R17: data enable filtered
  spc_ctl_filter #(.HOLD(FILTER_HOLD_CLOCKS)) u_de_filter (
    .clk(MCLK),
    .clr(down),
    .strobe(cap),
    .enable(filter_en_r),
    .din(DATA_ENABLE_IN),
    .dout(de_f)
  );

  spc_ctl_filter #(.HOLD(FILTER_HOLD_CLOCKS)) u_hs_filter (
    .clk(MCLK),
    .clr(down),
    .strobe(cap),
    .enable(filter_en_r),
    .din(HSYNC_IN),
    .dout(hs_f)
  );

  assign fifo_in = '{vsync: vs_r, hsync: hs_f, data_enable: de_f, pixel: pixel_r};

  spc_fifo #(.WIDTH(SYMBOL_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .flush(~POWER_DOWN_N),
    .in_valid(push_r),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(SYMBOL_VALID),
    .out_ready(SYMBOL_READY),
    .out_data(fifo_out)
  );

  // A symbol that meets a full FIFO is dropped; the sticky flag tells the source.
  always_ff @(posedge MCLK)
  begin
    if (down)
    begin
      overrun_r <= 1'b0;
    end
    else if (push_r & ~fifo_ready)
    begin
      overrun_r <= 1'b1;
    end
  end

  assign SYMBOL_OUT = spc_symbol_t'(fifo_out);
  assign PLL_LOCKED = pll_locked_r;
  assign SER_LEGS_HIGH = legs_high_r;
  assign LINK_MODE = mode_r;
  assign FILTER_ENABLE = filter_en_r;
  assign SELF_TEST_ACTIVE = bist_r;
  assign SWING_HIGH = swing_r;
  assign CAPTURE_OVERRUN = overrun_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_legs_high_down: assert property (!POWER_DOWN_N |=> SER_LEGS_HIGH && !PLL_LOCKED) // R8
    else $error("Serial legs not high in power-down.");
  a_normal_run: assert property (!down && state_r == SPC_PS_ACTIVE |=> !SER_LEGS_HIGH) // R7
    else $error("Legs held idle in normal operation.");
  a_regs_reset_down: assert property (!POWER_DOWN_N |=> !edge_ovr_en_r && !swing_ovr_en_r) // R9
    else $error("Control registers survived power-down.");
  a_lock_wait: assert property (@(posedge MCLK) disable iff (down) // R19
    state_r == SPC_PS_DOWN |=> !cap [*2] ##(LOCK_DLY - 1) state_r == SPC_PS_ACTIVE)
    else $error("Lock wait length is wrong.");
  a_idle_no_capture: assert property (state_r != SPC_PS_ACTIVE |-> !cap && !push_r [*1] ##1 !push_r) // R19
    else $error("Capture while link not locked.");
  a_rise_capture: assert property (active && edge_sel_r |-> cap == rise) // R5
    else $error("Rising edge capture mismatch.");
  a_fall_capture: assert property (active && !edge_sel_r |-> cap == fall) // R6
    else $error("Falling edge capture mismatch.");
  a_mode_filter: assert property (!down |=> FILTER_ENABLE == (LINK_MODE == SPC_MODE_NATIVE_FILT)) // R11
    else $error("Filter enable disagrees with mode.");
  a_mode_follow: assert property (!down ##1 !down |-> LINK_MODE == spc_mode_t'($past(CONFIG_SELECT))) // R12
    else $error("Link mode does not follow configuration.");
  a_swing_pin: assert property (!down && !swing_ovr_en_r |=> SWING_HIGH == $past(SWING_LEVEL_SELECT)) // R15
    else $error("Swing level ignores select input.");
  a_bist_pattern: assert property (cap && bist_r && !down |=> pixel_r == $past(bist_pat_r)) // R14
    else $error("Self-test pattern not inserted.");
  a_symbol_group: assert property (cap && !bist_r |=> // R18
    pixel_r == $past(PIXEL_WORD_IN) && vs_r == $past(VSYNC_IN) && push_r)
    else $error("Symbol fields not captured together.");

  c_bist_capture: cover property (cap && bist_r);
  c_fifo_full: cover property (push_r && !fifo_ready);
  c_relock: cover property (state_r == SPC_PS_LOCKING ##1 state_r == SPC_PS_ACTIVE);

endmodule : spc_input_ctrl

`default_nettype wire

//--- test/spc_sink_model.sv
// Consumer model for the symbol stream: it stalls on command and throttles otherwise.
`timescale 1ns/100ps
`default_nettype none

module spc_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  output logic ready
);
  logic [1:0] cnt_r;

  // Ready drops one cycle in four, so the block never sees a consumer that always keeps up.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_r <= 2'h0;
      ready <= 1'h0;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      ready <= !stall && (cnt_r != 2'h3);
    end
  end
endmodule : spc_sink_model

`default_nettype wire

//--- test/spc_input_ctrl_tb.sv
// Self-checking testbench for the parallel input control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module spc_input_ctrl_tb
  import spc_pkg::*;
;
  logic mclk = 1'h0, rst = 1'h1, pclk = 1'h0, de = 1'h0, hs = 1'h0, vs = 1'h0, pdn = 1'h1;
  logic esel = 1'h1, ste = 1'h0, swsel = 1'h0, regw = 1'h0, reov = 1'h0, rev = 1'h0;
  logic rsov = 1'h0, rsv = 1'h0, stall = 1'h0, eff = 1'h1, f_de = 1'h0, f_hs = 1'h0;
  logic [23:0] word = 24'h000000;
  logic [23:0] bist_n = BIST_SEED;
  logic [1:0] cfg = 2'h0;
  logic sym_valid, sym_ready, pll_locked, legs_high, filt_en, st_act, sw_high, overrun;
  spc_symbol_t sym_out;
  spc_symbol_t e_s;
  spc_mode_t link_mode;
  spc_symbol_t q[$];
  int c_de = 0, c_hs = 0, n_errors = 0, comparisons = 0, k;
  integer seed = 32'hdb5e8f17;

  initial forever #4 mclk = ~mclk;

  spc_input_ctrl u_spc_input_ctrl (
    .MCLK(mclk), .SYS_RST(rst), .PIXEL_CLOCK_IN(pclk), .PIXEL_WORD_IN(word),
    .DATA_ENABLE_IN(de), .HSYNC_IN(hs), .VSYNC_IN(vs), .POWER_DOWN_N(pdn),
    .CAPTURE_EDGE_SELECT(esel), .CONFIG_SELECT(cfg), .SELF_TEST_ENABLE(ste),
    .SWING_LEVEL_SELECT(swsel), .REG_WRITE(regw), .REG_EDGE_OVR_EN(reov), .REG_EDGE_VALUE(rev),
    .REG_SWING_OVR_EN(rsov), .REG_SWING_VALUE(rsv), .SYMBOL_READY(sym_ready),
    .SYMBOL_VALID(sym_valid), .SYMBOL_OUT(sym_out), .PLL_LOCKED(pll_locked),
    .SER_LEGS_HIGH(legs_high), .LINK_MODE(link_mode), .FILTER_ENABLE(filt_en),
    .SELF_TEST_ACTIVE(st_act), .SWING_HIGH(sw_high), .CAPTURE_OVERRUN(overrun)
  );

  spc_sink_model u_spc_sink_model (
    .clk(mclk),
    .rst(rst),
    .stall(stall),
    .ready(sym_ready)
  );

  // A control change counts only after it has been held for the filter's hold count of captures.
  function automatic logic flt(input logic raw, inout logic f, inout int c);
    if (cfg !== 2'h1 || raw === f)
      c = 0;
    else
      c++;
    if (cfg !== 2'h1 || c >= FILTER_HOLD_CLOCKS)
    begin
      f = raw;
      c = 0;
    end
    return f;
  endfunction : flt

  task automatic cap(input logic [23:0] w, input logic d, input logic h, input logic v);
    spc_symbol_t s;
    @(negedge mclk);
    word = w;
    de = d;
    hs = h;
    vs = v;
    pclk = eff;
    s.pixel = ste ? bist_n : w;
    if (ste)
      bist_n++;
    s.data_enable = flt(d, f_de, c_de);
    s.hsync = flt(h, f_hs, c_hs);
    s.vsync = v;
    q.push_back(s);
    repeat (2) @(negedge mclk);
    pclk = ~eff;
    // The word changes at the unselected edge, so a wrong-edge capture shows up.
    word = ~w;
    @(negedge mclk);
  endtask : cap

  task automatic run(input int n, input logic d, input logic h, input logic v);
    repeat (n) cap(24'($random(seed)), d, h, v);
  endtask : run

  task automatic edge_to(input logic e);
    eff = e;
    repeat (2) @(negedge mclk);
    pclk = ~e;
    repeat (2) @(negedge mclk);
  endtask : edge_to

  task automatic wait_lock;
    int n;
    n = 0;
    while (pll_locked !== 1'h1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400)
    begin
      n_errors++;
      report_and_stop();
    end
    else
    begin
      `CHK("lock_wait", 1'h1, n >= LOCK_WAIT_CYCLES)
      `CHK("legs_run", 1'h0, legs_high)
    end
  endtask : wait_lock

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // Valid and ready are both registered, so their settled values at the falling edge are the ones taken next.
  always @(negedge mclk)
  begin
    if (!rst && sym_valid === 1'h1 && sym_ready === 1'h1)
    begin
      if (q.size() == 0)
        `CHK("extra_symbol", 1'h0, 1'h1)
      else
      begin
        e_s = q.pop_front();
        `CHK("symbol", e_s, sym_out)
      end
    end
  end

  initial
  begin
    repeat (2) @(negedge mclk);
    `CHK("legs_reset", 1'h1, legs_high)
    `CHK("lock_reset", 1'h0, pll_locked)
    rst = 1'h0;
    wait_lock();
    for (k = 0; k < 4; k++)
    begin
      cfg = 2'(k);
      ste = k[0];
      swsel = k[1];
      repeat (2) @(negedge mclk);
      `CHK("mode", spc_mode_t'(k), link_mode)
      `CHK("filter", k == 1, filt_en)
      `CHK("self_test", k[0], st_act)
      `CHK("swing", k[1], sw_high)
    end
    cfg = 2'h0;
    ste = 1'h0;
    swsel = 1'h1;
    repeat (2) @(negedge mclk);
    // The source keeps control changes rare and vsync long.
    run(4, 1'h0, 1'h0, 1'h0);
    run(1, 1'h1, 1'h1, 1'h1);
    run(130, 1'h0, 1'h0, 1'h1);
    esel = 1'h0;
    edge_to(1'h0);
    run(135, 1'h0, 1'h0, 1'h0);
    // Short pulses are dropped, held ones pass.
    cfg = 2'h1;
    repeat (2) @(negedge mclk);
    run(2, 1'h1, 1'h1, 1'h0);
    run(130, 1'h0, 1'h0, 1'h0);
    run(3, 1'h1, 1'h1, 1'h0);
    run(130, 1'h0, 1'h0, 1'h0);
    esel = 1'h1;
    reov = 1'h1;
    rsov = 1'h1;
    regw = 1'h1;
    @(negedge mclk);
    regw = 1'h0;
    edge_to(1'h0);
    `CHK("swing_ovr", 1'h0, sw_high)
    run(10, 1'h0, 1'h0, 1'h0);
    stall = 1'h1;
    run(8, 1'h0, 1'h0, 1'h0);
    `CHK("overrun", 1'h1, overrun)
    stall = 1'h0;
    repeat (40) @(negedge mclk);
    q.delete();
    pdn = 1'h0;
    repeat (2) @(negedge mclk);
    `CHK("legs_down", 1'h1, legs_high)
    `CHK("lock_down", 1'h0, pll_locked)
    `CHK("overrun_clr", 1'h0, overrun)
    `CHK("swing_down", 1'h0, sw_high)
    f_de = 1'h0;
    f_hs = 1'h0;
    pdn = 1'h1;
    wait_lock();
    `CHK("swing_pin", 1'h1, sw_high)
    edge_to(1'h1);
    ste = 1'h1;
    repeat (2) @(negedge mclk);
    run(10, 1'h0, 1'h0, 1'h0);
    ste = 1'h0;
    repeat (40) @(negedge mclk);
    `CHK("drained", 1'h1, q.size() == 0)
    report_and_stop();
  end
endmodule : spc_input_ctrl_tb

`default_nettype wire
